/* logic/bpfe_consts.svh */
// constants of the backup power fault and event logic
// Contract
// R1 - enabled input over-voltage sets event bit 7, interrupt, bus-good low, switch open, Buck
// R2 - input over-current sets event bit 6, interrupt, input switch open, Buck mode
// R3 - storage short sets event bit 5, interrupt, storage-good low, disconnect open, converter stopped
// R4 - enabled reverse current sets event bit 4, interrupt, input switch open, Buck mode
// R5 - capacitance measurement done sets event bit 3 and interrupt only
// R6 - conversion done sets event bit 2 and interrupt only
// R7 - high temperature warning sets event bit 1 and interrupt only
// R8 - over-temperature sets bit 0, interrupt, switch open; Buck or all off by select
// R9 - storage over-voltage sets state bit 3, interrupt, converter stopped
// R10 - bus power failure sets state bit 2, interrupt, bus-good low, switch open, Buck
// R11 - input power failure sets state bit 1, interrupt, bus-good low, switch open, Buck
// R12 - bus below detect threshold enters Buck mode; bus-good low throughout Buck mode
// R13 - burst mode stops charger above 1.2V feedback, restarts below 1.17V
// R14 - interrupt only from unmasked events; masked events still set flags
// R15 - interrupt stays high until every pending event is cleared
// R16 - writing one clears a flag; writing zero leaves it alone
`ifndef BPFE_CONSTS_SVH
`define BPFE_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define BPFE_OFS_FLAG        5'h00
`define BPFE_OFS_FLAG_MASK   5'h04
`define BPFE_OFS_SYS         5'h08
`define BPFE_OFS_SYS_MASK    5'h0c
`define BPFE_OFS_LIMIT       5'h10
`define BPFE_OFS_PROT        5'h14
`define BPFE_OFS_POWER       5'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BPFE_FLAG_IN_OVP     7
`define BPFE_FLAG_IN_OCP     6
`define BPFE_FLAG_STR_SCP    5
`define BPFE_FLAG_REV        4
`define BPFE_FLAG_MEAS       3
`define BPFE_FLAG_ADC        2
`define BPFE_FLAG_TJ_WARN    1
`define BPFE_FLAG_TJ_SHDN    0
`define BPFE_SYS_TJ_SEL      4
`define BPFE_SYS_STR_OVP     3
`define BPFE_SYS_BUS_FAIL    2
`define BPFE_SYS_IN_FAIL     1
`define BPFE_SYS_BLK_ON      0
`define BPFE_LIMIT_OVP_DIS   7
`define BPFE_PROT_RBP_DIS    6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BPFE_RST_FLAG_MASK   8'h00
`define BPFE_RST_SYS_MASK    3'h0
`define BPFE_RST_TJ_SEL      1'h0
`define BPFE_RST_LIMIT       8'h00
`define BPFE_RST_PROT        8'h00

// ----------------------------------------------------------------------
// burst hysteresis thresholds on the storage feedback, in millivolts
// ----------------------------------------------------------------------
`define BPFE_FBS_STOP_MV     12'h4b0
`define BPFE_FBS_RESTART_MV  12'h492

`endif

/* logic/bpfe_pkg.sv */
// types of the backup power fault and event logic
package bpfe_pkg;

    typedef enum logic [0:0] {
        BPFE_BUS_IDLE = 1'b0,
        BPFE_BUS_DONE = 1'b1
    } bpfe_bus_t;

    typedef struct packed {
        bpfe_bus_t   bus;
        logic [31:0] rdata;
        logic [7:0]  flag;
        logic [7:0]  flag_mask;
        logic [3:1]  sys_flag;
        logic [3:1]  sys_mask;
        logic        tj_sel;
        logic [7:0]  limit_setup;
        logic [7:0]  prot_feat;
        logic        irq;
        logic        bus_good;
        logic        str_good;
        logic        blk_on;
        logic        str_sw_on;
        logic        buck;
        logic        conv_stop;
        logic        all_off;
        logic        boost_en;
    } bpfe_state_t;

    typedef struct packed {
        logic stop;
    } bpfe_hyst_t;

endpackage : bpfe_pkg

/* logic/bpfe_hyst.sv */
// hysteresis comparator that gates the boost charger in burst mode
`timescale 1ns/1ps
`include "bpfe_consts.svh"

module bpfe_hyst #(
    parameter logic [11:0] STOP_MV    = `BPFE_FBS_STOP_MV,
    parameter logic [11:0] RESTART_MV = `BPFE_FBS_RESTART_MV
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // feedback sample
    input  wire logic        i_enable,
    input  wire logic [11:0] i_fbs_mv,
    // result
    output logic             o_stop
);
    import bpfe_pkg::*;

    bpfe_hyst_t st;
    bpfe_hyst_t next_st;

    // ----------------------------------------------------------------------
    // hysteresis
    // ----------------------------------------------------------------------
    // the band between the two levels keeps the charger from chattering
    always_comb begin
        next_st = st;
        if (!i_enable) begin
            next_st.stop = 1'b0;
        end else if (i_fbs_mv > STOP_MV) begin
            next_st.stop = 1'b1; // [R13]
        end else if (i_fbs_mv < RESTART_MV) begin
            next_st.stop = 1'b0; // [R13]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_stop = st.stop;

endmodule : bpfe_hyst

/* logic/bpfe_event_logic.sv */
// fault and event logic of the backup power manager with avalon register slave
`timescale 1ns/1ps
`include "bpfe_consts.svh"

module bpfe_event_logic (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // avalon-mm slave
    input  wire logic [4:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    // fault and event detectors, active high levels
    input  wire logic        i_in_ovp,
    input  wire logic        i_in_ocp,
    input  wire logic        i_str_short,
    input  wire logic        i_rev_current,
    input  wire logic        i_meas_done,
    input  wire logic        i_adc_done,
    input  wire logic        i_tj_warn,
    input  wire logic        i_tj_shutdown,
    input  wire logic        i_str_ovp,
    input  wire logic        i_bus_fail,
    input  wire logic        i_in_fail,
    // bus comparator and burst control
    input  wire logic        i_bus_below_det,
    input  wire logic        i_burst_mode,
    input  wire logic [11:0] i_storage_feedback_mv,
    // interrupt and indicators
    output logic             o_int,
    output logic             o_bus_good_out,
    output logic             o_storage_good_out,
    // power path commands
    output logic             o_input_block_switch,
    output logic             o_storage_disconnect_switch,
    output logic             o_buck_mode,
    output logic             o_converter_stop,
    output logic             o_all_off,
    output logic             o_boost_en
);
    import bpfe_pkg::*;

    bpfe_state_t st;
    bpfe_state_t next_st;

    logic        burst_stop;
    logic        req;
    logic        wr_take;
    logic [7:0]  wbyte;
    logic [7:0]  flag_set;
    logic [3:1]  sys_set;
    logic [7:0]  flag_clr;
    logic [3:1]  sys_clr;
    logic        ovp_en;
    logic        rbp_en;
    logic        buck_req;
    logic        blk_open;
    logic        stop_req;
    logic        off_req;

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    function automatic logic reg_hit(input logic [4:0] addr, input logic [4:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    function automatic logic [31:0] read_mux(input bpfe_state_t s, input logic [4:0] addr);
        read_mux = 32'h0000_0000;
        if (reg_hit(addr, `BPFE_OFS_FLAG)) begin
            read_mux = {24'h00_0000, s.flag};
        end else if (reg_hit(addr, `BPFE_OFS_FLAG_MASK)) begin
            read_mux = {24'h00_0000, s.flag_mask};
        end else if (reg_hit(addr, `BPFE_OFS_SYS)) begin
            read_mux = {27'h000_0000, s.tj_sel, s.sys_flag, s.blk_on};
        end else if (reg_hit(addr, `BPFE_OFS_SYS_MASK)) begin
            read_mux = {28'h000_0000, s.sys_mask, 1'b0};
        end else if (reg_hit(addr, `BPFE_OFS_LIMIT)) begin
            read_mux = {24'h00_0000, s.limit_setup};
        end else if (reg_hit(addr, `BPFE_OFS_PROT)) begin
            read_mux = {24'h00_0000, s.prot_feat};
        end else if (reg_hit(addr, `BPFE_OFS_POWER)) begin
            read_mux = {23'h00_0000, s.boost_en, s.all_off, s.conv_stop, s.buck,
                        s.str_sw_on, s.blk_on, s.str_good, s.bus_good, s.irq};
        end
    endfunction : read_mux

    // ----------------------------------------------------------------------
    // burst mode comparator
    // ----------------------------------------------------------------------
    bpfe_hyst #(
        .STOP_MV    (`BPFE_FBS_STOP_MV),
        .RESTART_MV (`BPFE_FBS_RESTART_MV)
    ) u_hyst (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_enable (i_burst_mode),
        .i_fbs_mv (i_storage_feedback_mv),
        .o_stop   (burst_stop)
    );

    // ----------------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------------
    // one wait cycle per access so read data can come from a flop
    assign req           = i_read | i_write;
    assign o_waitrequest = req & (st.bus == BPFE_BUS_IDLE);
    assign wr_take       = i_write & (st.bus == BPFE_BUS_DONE) & i_byteenable[0];
    assign wbyte         = i_writedata[7:0];

    // ----------------------------------------------------------------------
    // event sources
    // ----------------------------------------------------------------------
    // enable bits are active low: zero enables the protection
    assign ovp_en = ~st.limit_setup[`BPFE_LIMIT_OVP_DIS];
    assign rbp_en = ~st.prot_feat[`BPFE_PROT_RBP_DIS];

    always_comb begin
        flag_set = 8'h00;
        flag_set[`BPFE_FLAG_IN_OVP]  = i_in_ovp & ovp_en;       // [R1]
        flag_set[`BPFE_FLAG_IN_OCP]  = i_in_ocp;                // [R2]
        flag_set[`BPFE_FLAG_STR_SCP] = i_str_short;             // [R3]
        flag_set[`BPFE_FLAG_REV]     = i_rev_current & rbp_en;  // [R4]
        flag_set[`BPFE_FLAG_MEAS]    = i_meas_done;             // [R5]
        flag_set[`BPFE_FLAG_ADC]     = i_adc_done;              // [R6]
        flag_set[`BPFE_FLAG_TJ_WARN] = i_tj_warn;               // [R7]
        flag_set[`BPFE_FLAG_TJ_SHDN] = i_tj_shutdown;           // [R8]
    end

    always_comb begin
        sys_set = 3'h0;
        sys_set[`BPFE_SYS_STR_OVP]  = i_str_ovp;   // [R9]
        sys_set[`BPFE_SYS_BUS_FAIL] = i_bus_fail;  // [R10]
        sys_set[`BPFE_SYS_IN_FAIL]  = i_in_fail;   // [R11]
    end

    // only bits written as one are cleared
    always_comb begin
        flag_clr = 8'h00;
        sys_clr  = 3'h0;
        if (wr_take && reg_hit(i_address, `BPFE_OFS_FLAG)) begin
            flag_clr = wbyte;                       // [R16]
        end
        if (wr_take && reg_hit(i_address, `BPFE_OFS_SYS)) begin
            sys_clr = wbyte[3:1];                   // [R16]
        end
    end

    // ----------------------------------------------------------------------
    // power path decisions
    // ----------------------------------------------------------------------
    // actions track the latched flags, so a fault keeps its action until
    // software clears the flag and the detector has gone quiet
    always_comb begin
        off_req  = next_st.flag[`BPFE_FLAG_TJ_SHDN] & next_st.tj_sel;   // [R8]
        blk_open = next_st.flag[`BPFE_FLAG_IN_OVP]                      // [R1]
                 | next_st.flag[`BPFE_FLAG_IN_OCP]                      // [R2]
                 | next_st.flag[`BPFE_FLAG_REV]                         // [R4]
                 | next_st.flag[`BPFE_FLAG_TJ_SHDN]                     // [R8]
                 | next_st.sys_flag[`BPFE_SYS_BUS_FAIL]                 // [R10]
                 | next_st.sys_flag[`BPFE_SYS_IN_FAIL];                 // [R11]
        // every fault that opens the input switch also asks for Buck mode, unless off_req forces all off
        buck_req = ~off_req & (i_bus_below_det | blk_open);             // [R12]
        stop_req = off_req
                 | next_st.flag[`BPFE_FLAG_STR_SCP]                     // [R3]
                 | next_st.sys_flag[`BPFE_SYS_STR_OVP];                 // [R9]
    end

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // bus phase and read data
        unique case (st.bus)
            BPFE_BUS_IDLE: begin
                if (req) begin
                    next_st.bus   = BPFE_BUS_DONE;
                    next_st.rdata = read_mux(st, i_address);
                end
            end
            BPFE_BUS_DONE: begin
                next_st.bus = BPFE_BUS_IDLE;
            end
        endcase

        // an event in the clearing cycle wins over the clear
        next_st.flag     = (st.flag & ~flag_clr) | flag_set;               // [R14] [R16]
        next_st.sys_flag = (st.sys_flag & ~sys_clr) | sys_set;             // [R14] [R16]

        // plain control writes
        if (wr_take && reg_hit(i_address, `BPFE_OFS_FLAG_MASK)) begin
            next_st.flag_mask = wbyte;
        end
        if (wr_take && reg_hit(i_address, `BPFE_OFS_SYS_MASK)) begin
            next_st.sys_mask = wbyte[3:1];
        end
        if (wr_take && reg_hit(i_address, `BPFE_OFS_SYS)) begin
            next_st.tj_sel = wbyte[`BPFE_SYS_TJ_SEL];
        end
        if (wr_take && reg_hit(i_address, `BPFE_OFS_LIMIT)) begin
            next_st.limit_setup = wbyte;
        end
        if (wr_take && reg_hit(i_address, `BPFE_OFS_PROT)) begin
            next_st.prot_feat = wbyte;
        end

        // level interrupt from every pending unmasked event
        next_st.irq = |(next_st.flag & ~next_st.flag_mask)
                    | |(next_st.sys_flag & ~next_st.sys_mask);             // [R14] [R15]

        // power path outputs
        next_st.all_off   = off_req;                                       // [R8]
        next_st.buck      = buck_req;                                      // [R12]
        next_st.blk_on    = ~(blk_open | off_req);                         // [R1] [R8]
        next_st.str_sw_on = ~(next_st.flag[`BPFE_FLAG_STR_SCP] | off_req); // [R3]
        next_st.conv_stop = stop_req;                                      // [R3] [R9]
        next_st.bus_good  = ~(buck_req | off_req);                         // [R1] [R10] [R11] [R12]
        next_st.str_good  = ~next_st.flag[`BPFE_FLAG_STR_SCP];             // [R3]
        // charger runs only outside Buck mode, converter stop and burst pause
        next_st.boost_en  = ~buck_req & ~stop_req & ~burst_stop;           // [R13]
    end

    // ----------------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st             <= '0;
            st.bus         <= BPFE_BUS_IDLE;
            st.flag_mask   <= `BPFE_RST_FLAG_MASK;
            st.sys_mask    <= `BPFE_RST_SYS_MASK;
            st.tj_sel      <= `BPFE_RST_TJ_SEL;
            st.limit_setup <= `BPFE_RST_LIMIT;
            st.prot_feat   <= `BPFE_RST_PROT;
            st.bus_good    <= 1'b1;
            st.str_good    <= 1'b1;
            st.blk_on      <= 1'b1;
            st.str_sw_on   <= 1'b1;
            st.boost_en    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    assign o_readdata                  = st.rdata;
    assign o_int                       = st.irq;
    assign o_bus_good_out              = st.bus_good;
    assign o_storage_good_out          = st.str_good;
    assign o_input_block_switch        = st.blk_on;
    assign o_storage_disconnect_switch = st.str_sw_on;
    assign o_buck_mode                 = st.buck;
    assign o_converter_stop            = st.conv_stop;
    assign o_all_off                   = st.all_off;
    assign o_boost_en                  = st.boost_en;

endmodule : bpfe_event_logic

/* bench/bpfe_event_logic_asserts.sv */
// concurrent checks on the ports of the fault and event logic
`timescale 1ns/1ps
`include "bpfe_consts.svh"

module bpfe_chk (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rstn,
    // register bus
    input wire logic        i_read,
    input wire logic        i_write,
    input wire logic        o_waitrequest,
    // detectors
    input wire logic        i_in_ovp,
    input wire logic        i_in_ocp,
    input wire logic        i_str_short,
    input wire logic        i_rev_current,
    input wire logic        i_meas_done,
    input wire logic        i_adc_done,
    input wire logic        i_tj_warn,
    input wire logic        i_tj_shutdown,
    input wire logic        i_str_ovp,
    input wire logic        i_bus_fail,
    input wire logic        i_in_fail,
    input wire logic        i_bus_below_det,
    input wire logic        i_burst_mode,
    input wire logic [11:0] i_storage_feedback_mv,
    // outputs under check
    input wire logic        o_int,
    input wire logic        o_bus_good_out,
    input wire logic        o_storage_good_out,
    input wire logic        o_input_block_switch,
    input wire logic        o_storage_disconnect_switch,
    input wire logic        o_buck_mode,
    input wire logic        o_converter_stop,
    input wire logic        o_all_off,
    input wire logic        o_boost_en
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    wire logic ev_any  = i_in_ovp | i_in_ocp | i_str_short | i_rev_current | i_meas_done | i_adc_done
                       | i_tj_warn | i_tj_shutdown | i_str_ovp | i_bus_fail | i_in_fail;
    wire logic wr_done = i_write & ~o_waitrequest;

    sequence s_req;
        (i_read || i_write) && o_waitrequest;
    endsequence
    sequence s_burst_hi;
        i_burst_mode && (i_storage_feedback_mv > `BPFE_FBS_STOP_MV);
    endsequence

    property p_ack;
        s_req |=> !o_waitrequest;
    endproperty
    property p_ocp;
        i_in_ocp |=> !o_input_block_switch && (o_buck_mode || o_all_off) && !o_boost_en;
    endproperty
    property p_short;
        i_str_short |=> !o_storage_good_out && !o_storage_disconnect_switch && o_converter_stop;
    endproperty
    property p_str_ovp;
        i_str_ovp |=> o_converter_stop && !o_boost_en;
    endproperty
    property p_pwr_fail;
        (i_bus_fail || i_in_fail) |=> !o_bus_good_out && !o_input_block_switch;
    endproperty
    property p_tj_shdn;
        i_tj_shutdown |=> !o_input_block_switch && (o_buck_mode ^ o_all_off);
    endproperty
    property p_all_off;
        o_all_off |-> !o_buck_mode && o_converter_stop && !o_bus_good_out;
    endproperty
    property p_buck_good;
        i_bus_below_det |=> (o_buck_mode || o_all_off) && !o_bus_good_out;
    endproperty
    property p_burst;
        s_burst_hi |-> ##2 !o_boost_en;
    endproperty
    property p_int_rise;
        $rose(o_int) |-> $past(ev_any) || $past(wr_done);
    endproperty
    property p_int_fall;
        $fell(o_int) |-> $past(wr_done);
    endproperty

    a_ack:       assert property (p_ack)       else $error("bus wait not one cycle");
    a_ocp:       assert property (p_ocp)       else $error("over-current action missing");
    a_short:     assert property (p_short)     else $error("storage short action missing");
    a_str_ovp:   assert property (p_str_ovp)   else $error("storage over-voltage action missing");
    a_pwr_fail:  assert property (p_pwr_fail)  else $error("power fail action missing");
    a_tj_shdn:   assert property (p_tj_shdn)   else $error("thermal shutdown action missing");
    a_all_off:   assert property (p_all_off)   else $error("all off state inconsistent");
    a_buck_good: assert property (p_buck_good) else $error("bus detect not in buck");
    a_burst:     assert property (p_burst)     else $error("charger not stopped");
    a_int_rise:  assert property (p_int_rise)  else $error("interrupt rose without cause");
    a_int_fall:  assert property (p_int_fall)  else $error("interrupt fell without clear");
endmodule : bpfe_chk

bind bpfe_event_logic bpfe_chk u_chk (.*);

/* bench/bpfe_host.sv */
// host model: avalon master that reads and clears the event flags
`timescale 1ns/1ps

module bpfe_host (
    // clock
    input wire logic         i_clk,
    // avalon master
    output logic [4:0]       o_address,
    output logic             o_read,
    output logic             o_write,
    output logic [31:0]      o_writedata,
    output logic [3:0]       o_byteenable,
    input wire logic [31:0]  i_readdata,
    input wire logic         i_waitrequest
);
    initial begin
        o_address    = 5'h00;
        o_read       = 1'b0;
        o_write      = 1'b0;
        o_writedata  = 32'h0;
        o_byteenable = 4'h1;
    end

    // at the flag offsets a one bit in d clears that flag, zeros leave flags alone
    task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_address   <= a;
        o_writedata <= {24'h0, d};
        o_write     <= 1'b1;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        o_write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_address <= a;
        o_read    <= 1'b1;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        d = i_readdata;
        o_read <= 1'b0;
    endtask : bus_rd
endmodule : bpfe_host

/* bench/bpfe_event_logic_tb.sv */
// self-checking bench of the fault and event logic
`timescale 1ns/1ps

module bpfe_event_logic_tb;
    import bpfe_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic [10:0] ev = 11'h0;
    logic        below = 1'b0;
    logic        burst = 1'b0;
    logic [11:0] fbs = 12'h000;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;
    wire logic [4:0]  adr;
    wire logic        rd, wr, wrq;
    wire logic [31:0] wdat, rdat;
    wire logic [3:0]  be;
    wire logic o_int, bg, sg, insw, strsw, buck, cstop, aoff, boost;
    wire logic [8:0] pins = {boost, aoff, cstop, buck, strsw, insw, sg, bg, o_int};
    // event order: ovp ocp short rev meas adc warn tjsd strovp busfail infail
    logic [4:0] t_ofs [11] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h08, 5'h08, 5'h08};
    logic [7:0] t_bit [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h08, 8'h04, 8'h02};
    logic [8:0] t_pwr [11] = '{9'h035, 9'h035, 9'h04b, 9'h035, 9'h11f, 9'h11f, 9'h11f, 9'h035, 9'h05f,
                               9'h035, 9'h035};
    logic [31:0] t_rst [8] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h11e, 32'h0};

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    bpfe_host host (.i_clk(i_clk), .o_address(adr), .o_read(rd), .o_write(wr), .o_writedata(wdat),
        .o_byteenable(be), .i_readdata(rdat), .i_waitrequest(wrq));

    bpfe_event_logic DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_address(adr), .i_read(rd), .i_write(wr),
        .i_writedata(wdat), .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wrq),
        .i_in_ovp(ev[0]), .i_in_ocp(ev[1]), .i_str_short(ev[2]), .i_rev_current(ev[3]),
        .i_meas_done(ev[4]), .i_adc_done(ev[5]), .i_tj_warn(ev[6]), .i_tj_shutdown(ev[7]),
        .i_str_ovp(ev[8]), .i_bus_fail(ev[9]), .i_in_fail(ev[10]), .i_bus_below_det(below),
        .i_burst_mode(burst), .i_storage_feedback_mv(fbs), .o_int(o_int), .o_bus_good_out(bg),
        .o_storage_good_out(sg), .o_input_block_switch(insw), .o_storage_disconnect_switch(strsw),
        .o_buck_mode(buck), .o_converter_stop(cstop), .o_all_off(aoff), .o_boost_en(boost));

    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_reg

    // pins sampled at the falling edge, after the rising edge updates landed
    task automatic chk_pin(input logic [8:0] e);
        @(negedge i_clk);
        checks_done++;
        if (pins !== e) begin
            miscompares++;
            $display("wrong value output pins expected %h seen %h", e, pins);
        end
    endtask : chk_pin

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] d;
        host.bus_rd(a, d);
        chk_reg("register", e, d);
    endtask : rd_chk

    task automatic pulse(input int k);
        @(posedge i_clk);
        ev[k] <= 1'b1;
        @(posedge i_clk);
        ev[k] <= 1'b0;
    endtask : pulse

    // feedback change shows on the charger two edges after it is driven
    task automatic burst_step(input logic [11:0] fb, input logic e);
        @(posedge i_clk);
        burst <= 1'b1;
        fbs   <= fb;
        repeat (2) @(posedge i_clk);
        chk_pin({e, 8'h1e});
    endtask : burst_step

    task automatic final_report;
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // hang guard, well above the length of the sequence below
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        logic [31:0] e;
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int a = 0; a < 8; a++) rd_chk(5'(a * 4), t_rst[a]);
        for (int k = 0; k < 11; k++) begin
            e = {24'h0, t_bit[k] | ((t_ofs[k] == 5'h08) ? {7'h0, t_pwr[k][3]} : 8'h00)};
            pulse(k);
            chk_pin(t_pwr[k]);
            rd_chk(t_ofs[k], e);
            host.bus_wr(t_ofs[k], 8'h00);
            rd_chk(t_ofs[k], e);
            host.bus_wr(t_ofs[k], t_bit[k]);
            rd_chk(t_ofs[k], {31'h0, t_ofs[k] == 5'h08});
            chk_pin(9'h11e);
        end
        host.bus_wr(5'h04, 8'hff);
        pulse(5);
        chk_pin(9'h11e);
        rd_chk(5'h00, 32'h4);
        host.bus_wr(5'h04, 8'h00);
        chk_pin(9'h11f);
        host.bus_wr(5'h00, 8'h04);
        host.bus_wr(5'h0c, 8'h0e);
        pulse(8);
        chk_pin(9'h05e);
        host.bus_wr(5'h08, 8'h08);
        host.bus_wr(5'h0c, 8'h00);
        pulse(4);
        pulse(6);
        host.bus_wr(5'h00, 8'h08);
        chk_pin(9'h11f);
        host.bus_wr(5'h00, 8'h02);
        chk_pin(9'h11e);
        host.bus_wr(5'h10, 8'h80);
        pulse(0);
        chk_pin(9'h11e);
        rd_chk(5'h10, 32'h80);
        host.bus_wr(5'h10, 8'h00);
        host.bus_wr(5'h14, 8'h40);
        pulse(3);
        chk_pin(9'h11e);
        rd_chk(5'h00, 32'h0);
        host.bus_wr(5'h14, 8'h00);
        host.bus_wr(5'h08, 8'h10);
        pulse(7);
        chk_pin(9'h0c5);
        rd_chk(5'h08, 32'h10);
        host.bus_wr(5'h00, 8'h01);
        host.bus_wr(5'h08, 8'h00);
        chk_pin(9'h11e);
        host.bus_wr(5'h1c, 8'hff);
        rd_chk(5'h1c, 32'h0);
        rd_chk(5'h00, 32'h0);
        @(posedge i_clk);
        below <= 1'b1;
        @(posedge i_clk);
        chk_pin(9'h03c);
        @(posedge i_clk);
        below <= 1'b0;
        @(posedge i_clk);
        chk_pin(9'h11e);
        burst_step(12'h4b0, 1'b1);
        burst_step(12'h4b1, 1'b0);
        burst_step(12'h492, 1'b0);
        burst_step(12'h491, 1'b1);
        final_report();
    end
endmodule : bpfe_event_logic_tb
